// ===== logic/serial_channel_status_control.v
// Status, error flags and run control of a two-channel serial unit
`timescale 1ns/10ps
`default_nettype none
`include "serial_status_defines.vh"

module serial_channel_status_control (
   // Clock and reset
   input wire i_clk,
   input wire i_rst,
   // Memory-mapped byte access
   input wire [`ADDR_W-1:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   // Channel configuration from the mode registers
   input wire [1:0] i_receive_enable_bit,
   input wire [1:0] i_transmit_enable,
   input wire [1:0] i_slave_transmit_mode,
   input wire [1:0] i_parity_enable,
   input wire [1:0] i_parity_odd,
   // Transfer engine events, one bit per channel; receive data one byte per channel
   input wire [1:0] i_transfer_start,
   input wire [1:0] i_transfer_end,
   input wire [1:0] i_rx_done,
   input wire [1:0] i_rx_stop_ok,
   input wire [15:0] i_rx_data,
   input wire [1:0] i_rx_parity_bit,
   input wire [1:0] i_rx_store,
   input wire [1:0] i_tx_taken,
   input wire [1:0] i_engine_clock,
   // Data buffer accesses by software
   input wire [1:0] i_buffer_write,
   input wire [1:0] i_buffer_read,
   // Channel control towards the engine and pins
   output wire [1:0] o_serial_clock_pin,
   output wire [1:0] o_channel_enabled,
   output wire [1:0] o_channel_abort,
   output wire [1:0] o_channel_halt
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // Odd parity inverts the expected bit
   function parity_calc;
      input [7:0] data;
      input odd;
      begin
         parity_calc = (^data) ^ odd;
      end
   endfunction

   function [7:0] status_byte;
      input active;
      input full;
      input [2:0] flags;
      begin
         status_byte = 8'h00;
         status_byte[`BIT_TRANSFER_ACTIVE] = active;
         status_byte[`BIT_BUFFER_FULL] = full;
         status_byte[`BIT_FRAMING] = flags[2];
         status_byte[`BIT_PARITY] = flags[1];
         status_byte[`BIT_OVERRUN] = flags[0];
      end
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   // Per-channel vectors: bit n belongs to channel n, except the flag clear and read data registers
   reg [1:0] channel_enabled_reg;
   reg [1:0] channel_enabled_next;
   reg [1:0] channel_start_reg;
   reg [1:0] channel_start_next;
   reg [1:0] channel_stop_reg;
   reg [1:0] channel_stop_next;
   reg [1:0] clock_output_level_reg;
   reg [1:0] clock_output_level_next;
   reg [2:0] flag_clear0_reg;
   reg [2:0] flag_clear0_next;
   reg [2:0] flag_clear1_reg;
   reg [2:0] flag_clear1_next;
   reg [1:0] transfer_active_reg;
   reg [1:0] transfer_active_next;
   reg [1:0] buffer_full_reg;
   reg [1:0] buffer_full_next;
   reg [7:0] rdata_next;

   wire [2:0] flags0;
   wire [2:0] flags1;
   wire [1:0] framing_set;
   wire [1:0] parity_set;
   wire [1:0] overrun_set;
   wire [1:0] rx_error;

   // ----------------------------------------
   // Register write decode
   // ----------------------------------------
   // Exact byte address match, one access per cycle
   wire wr_start = i_wr && (i_addr == `ADDR_START);
   wire wr_stop = i_wr && (i_addr == `ADDR_STOP);
   wire wr_clk_level = i_wr && (i_addr == `ADDR_CLK_LEVEL);
   wire wr_clr0 = i_wr && (i_addr == `ADDR_FLAG_CLR0);
   wire wr_clr1 = i_wr && (i_addr == `ADDR_FLAG_CLR1);

   // ----------------------------------------
   // Error event detection
   // ----------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_events
         wire rx_on = i_receive_enable_bit[ch];
         wire computed = parity_calc(i_rx_data[8*ch+7:8*ch], i_parity_odd[ch]);
         // missing stop bit, channel 1 only
         // Channel 0 must not see one, or its buffer-full flag would rise
         assign framing_set[ch] = (ch == 1) && i_rx_done[ch] && rx_on
                                  && !i_rx_stop_ok[ch];
         assign parity_set[ch] = i_rx_done[ch] && rx_on && i_parity_enable[ch]
                                 && (computed != i_rx_parity_bit[ch]);
         // unread data overwritten, write while full, slave underrun
         assign overrun_set[ch] = (i_buffer_write[ch] && buffer_full_reg[ch])
                                  || (i_rx_store[ch] && rx_on && buffer_full_reg[ch])
                                  || (i_transfer_start[ch] && channel_enabled_reg[ch]
                                      && i_slave_transmit_mode[ch]
                                      && i_transmit_enable[ch] && !buffer_full_reg[ch]);
         // Reception errors also mark the buffer full
         assign rx_error[ch] = framing_set[ch] || parity_set[ch];
      end
   endgenerate

   // ----------------------------------------
   // Error flags per channel
   // ----------------------------------------
   // no framing on channel 0
   channel_error_flags #(
      .HAS_FRAMING(0)
   ) u_flags0 (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_framing_set(1'b0),
      .i_parity_set(parity_set[0]),
      .i_overrun_set(overrun_set[0]),
      .i_clear(flag_clear0_reg),
      .o_flags(flags0)
   );

   // framing detection lives on channel 1
   channel_error_flags #(
      .HAS_FRAMING(1)
   ) u_flags1 (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_framing_set(framing_set[1]),
      .i_parity_set(parity_set[1]),
      .i_overrun_set(overrun_set[1]),
      .i_clear(flag_clear1_reg),
      .o_flags(flags1)
   );

   // ----------------------------------------
   // Flag clear triggers
   // ----------------------------------------
   // Held one cycle, then gone whether or not the flags have dropped
   // A flag event in that same cycle still wins
   always @* begin
      flag_clear0_next = `RST_FLAG_CLR;
      flag_clear1_next = `RST_FLAG_CLR;
      if (wr_clr0) begin
         // no framing trigger on channel 0
         flag_clear0_next = {1'b0, i_wdata[1:0]};
      end
      if (wr_clr1) begin
         flag_clear1_next = i_wdata[2:0];
      end
   end

   // ----------------------------------------
   // Start, stop and enable status
   // ----------------------------------------
   always @* begin
      // Start and stop never pend together: each write reaches one register
      // start trigger self-clears once enabled, stop once disabled
      channel_start_next = channel_start_reg & ~channel_enabled_next;
      channel_stop_next = channel_stop_reg & channel_enabled_next;
      if (wr_start) begin
         channel_start_next = i_wdata[1:0];
      end
      if (wr_stop) begin
         channel_stop_next = i_wdata[1:0];
      end
   end

   always @* begin
      // start sets enable, stop clears it
      channel_enabled_next = (channel_enabled_reg | channel_start_reg) & ~channel_stop_reg;
   end

   // abort request to the engine is the start trigger itself
   assign o_channel_abort = channel_start_reg;
   assign o_channel_halt = channel_stop_reg;
   assign o_channel_enabled = channel_enabled_reg;

   // ----------------------------------------
   // Transfer-active and buffer-full flags
   // ----------------------------------------
   // One loop index per process, so each has a single driver
   integer n;
   integer m;
   always @* begin
      transfer_active_next = transfer_active_reg;
      buffer_full_next = buffer_full_reg;
      for (n = 0; n < 2; n = n + 1) begin
         // set at start wins over clears
         if (i_transfer_start[n] && channel_enabled_reg[n]) begin
            transfer_active_next[n] = 1'b1;
         end else if (i_transfer_end[n] || channel_start_reg[n] || channel_stop_reg[n]) begin
            transfer_active_next[n] = 1'b0;
         end
         // Start and stop drop stale buffer contents as well
         if ((i_buffer_write[n] && i_transmit_enable[n])
             || (i_rx_store[n] && i_receive_enable_bit[n]) || rx_error[n]) begin
            buffer_full_next[n] = 1'b1;
         end else if (i_tx_taken[n] || i_buffer_read[n]
                      || channel_start_reg[n] || channel_stop_reg[n]) begin
            buffer_full_next[n] = 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Clock output level
   // ----------------------------------------
   // Pin is a flop copy, so it lags the engine by one cycle
   always @* begin
      clock_output_level_next = clock_output_level_reg;
      for (m = 0; m < 2; m = m + 1) begin
         if (channel_enabled_reg[m]) begin
            clock_output_level_next[m] = i_engine_clock[m];
         end else if (wr_clk_level) begin
            clock_output_level_next[m] = i_wdata[m];
         end
      end
   end

   assign o_serial_clock_pin = clock_output_level_reg;

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   // Registered data, valid the cycle after the strobe, zero otherwise
   always @* begin
      rdata_next = `READ_ZERO;
      if (i_rd) begin
         case (i_addr)
            `ADDR_STATUS0: begin
               rdata_next = status_byte(transfer_active_reg[0], buffer_full_reg[0], flags0);
            end
            `ADDR_STATUS1: begin
               rdata_next = status_byte(transfer_active_reg[1], buffer_full_reg[1], flags1);
            end
            `ADDR_ENABLE: begin
               rdata_next = {6'h00, channel_enabled_reg};
            end
            `ADDR_CLK_LEVEL: begin
               rdata_next = {6'h00, clock_output_level_reg};
            end
            `ADDR_START: begin
               rdata_next = `READ_ZERO;
            end
            `ADDR_STOP: begin
               rdata_next = `READ_ZERO;
            end
            default: begin
               rdata_next = `READ_ZERO;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // No clock enable: every register updates on every edge
   always @(posedge i_clk) begin
      if (i_rst) begin
         channel_enabled_reg <= `RST_ENABLE;
         channel_start_reg <= `RST_TRIGGER;
         channel_stop_reg <= `RST_TRIGGER;
         clock_output_level_reg <= `RST_CLK_LEVEL;
         flag_clear0_reg <= `RST_FLAG_CLR;
         flag_clear1_reg <= `RST_FLAG_CLR;
         transfer_active_reg <= `RST_STATUS;
         buffer_full_reg <= `RST_STATUS;
         o_rdata <= `RST_RDATA;
      end else begin
         channel_enabled_reg <= channel_enabled_next;
         channel_start_reg <= channel_start_next;
         channel_stop_reg <= channel_stop_next;
         clock_output_level_reg <= clock_output_level_next;
         flag_clear0_reg <= flag_clear0_next;
         flag_clear1_reg <= flag_clear1_next;
         transfer_active_reg <= transfer_active_next;
         buffer_full_reg <= buffer_full_next;
         o_rdata <= rdata_next;
      end
   end

endmodule // serial_channel_status_control

`default_nettype wire

// ===== logic/serial_status_defines.vh
// Constants for the serial channel status and run-control block
`ifndef SERIAL_STATUS_DEFINES_VH
`define SERIAL_STATUS_DEFINES_VH

// ----------------------------------------
// Register addresses (byte addresses)
// ----------------------------------------
`define ADDR_W 20
`define ADDR_STATUS0 20'hF0100
`define ADDR_STATUS1 20'hF0102
`define ADDR_FLAG_CLR0 20'hF0108
`define ADDR_FLAG_CLR1 20'hF010A
`define ADDR_ENABLE 20'hF0120
`define ADDR_START 20'hF0122
`define ADDR_STOP 20'hF0124
`define ADDR_CLK_LEVEL 20'hF0129

// ----------------------------------------
// Status register bit positions
// ----------------------------------------
`define BIT_TRANSFER_ACTIVE 6
`define BIT_BUFFER_FULL 5
`define BIT_FRAMING 2
`define BIT_PARITY 1
`define BIT_OVERRUN 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_ENABLE 2'h0
`define RST_TRIGGER 2'h0
`define RST_FLAG_CLR 3'h0
`define RST_STATUS 2'h0
`define RST_CLK_LEVEL 2'h3
`define RST_RDATA 8'h00
`define READ_ZERO 8'h00

`endif

// ===== logic/channel_error_flags.v
// Sticky framing, parity and overrun flags of one channel
`timescale 1ns/10ps
`default_nettype none

module channel_error_flags #(
   parameter HAS_FRAMING = 1
) (
   // Clock and reset
   input wire i_clk,
   input wire i_rst,
   // Error events
   input wire i_framing_set,
   input wire i_parity_set,
   input wire i_overrun_set,
   // Clear triggers {framing, parity, overrun}
   input wire [2:0] i_clear,
   // Flags {framing, parity, overrun}
   output wire [2:0] o_flags
);

   reg framing_error_flag_reg;
   reg parity_error_flag_reg;
   reg overrun_error_flag_reg;

   // ----------------------------------------
   // Flag update
   // ----------------------------------------
   // Set beats clear so no event is lost
   always @(posedge i_clk) begin
      if (i_rst) begin
         framing_error_flag_reg <= 1'b0;
         parity_error_flag_reg <= 1'b0;
         overrun_error_flag_reg <= 1'b0;
      end else begin
         if (HAS_FRAMING == 0)
            framing_error_flag_reg <= 1'b0;
         else if (i_framing_set)
            framing_error_flag_reg <= 1'b1;
         else if (i_clear[2])
            framing_error_flag_reg <= 1'b0;
         if (i_parity_set)
            parity_error_flag_reg <= 1'b1;
         else if (i_clear[1])
            parity_error_flag_reg <= 1'b0;
         if (i_overrun_set)
            overrun_error_flag_reg <= 1'b1;
         else if (i_clear[0])
            overrun_error_flag_reg <= 1'b0;
      end
   end

   assign o_flags = {framing_error_flag_reg, parity_error_flag_reg, overrun_error_flag_reg};

endmodule // channel_error_flags

`default_nettype wire

// ===== tb/serial_status_checker_asserts.sv
// Concurrent checks on the serial status and run-control block
`timescale 1ns/10ps
`default_nettype none
`include "serial_status_defines.vh"
module serial_status_checker (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [`ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic [1:0] i_engine_clock,
   input wire logic [1:0] o_serial_clock_pin,
   input wire logic [1:0] o_channel_enabled,
   input wire logic [1:0] o_channel_abort,
   input wire logic [1:0] o_channel_halt
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire rd_trig = i_rd && (i_addr == `ADDR_START || i_addr == `ADDR_STOP);
   wire wr_lvl = i_wr && i_addr == `ADDR_CLK_LEVEL;
   start_abort_a: assert property (
      i_wr && i_addr == `ADDR_START |=> (o_channel_abort & $past(i_wdata[1:0])) == $past(i_wdata[1:0]))
      else $error("start write gave no abort pulse");
   abort_enable_a: assert property (
      o_channel_abort != 2'h0 |=> (o_channel_enabled & $past(o_channel_abort)) == $past(o_channel_abort))
      else $error("abort pulse did not enable channel");
   halt_disable_a: assert property (
      o_channel_halt != 2'h0 |=> (o_channel_enabled & $past(o_channel_halt)) == 2'h0)
      else $error("halt pulse did not disable channel");
   enable_hold_a: assert property (
      (o_channel_abort | o_channel_halt) == 2'h0 |=> $stable(o_channel_enabled))
      else $error("enable changed without trigger");
   trig_zero_a: assert property (
      rd_trig |=> o_rdata == 8'h00)
      else $error("trigger register read not zero");
   enable_read_a: assert property (
      i_rd && i_addr == `ADDR_ENABLE |=> o_rdata == {6'h00, $past(o_channel_enabled)})
      else $error("enable read mismatch");
   pin_follow_a: assert property (
      o_channel_enabled != 2'h0 |=>
      ((o_serial_clock_pin ^ $past(i_engine_clock)) & $past(o_channel_enabled)) == 2'h0)
      else $error("clock pin not following engine");
   pin_soft_a: assert property (
      wr_lvl && !o_channel_enabled[0] |=> o_serial_clock_pin[0] == $past(i_wdata[0]))
      else $error("clock pin not software level");
   status0_pad_a: assert property (
      i_rd && i_addr == `ADDR_STATUS0 |=> (o_rdata & 8'h9C) == 8'h00)
      else $error("status0 reserved bits set");
   status1_pad_a: assert property (
      i_rd && i_addr == `ADDR_STATUS1 |=> (o_rdata & 8'h98) == 8'h00)
      else $error("status1 reserved bits set");
   cover property (o_channel_abort[0] && o_channel_enabled[0]);
   cover property (o_channel_halt != 2'h0);
   cover property (i_rd && i_addr == `ADDR_STATUS1 ##1 o_rdata[2]);
endmodule // serial_status_checker
bind serial_channel_status_control serial_status_checker chk (
   .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
   .o_rdata(o_rdata), .i_engine_clock(i_engine_clock), .o_serial_clock_pin(o_serial_clock_pin),
   .o_channel_enabled(o_channel_enabled), .o_channel_abort(o_channel_abort), .o_channel_halt(o_channel_halt)
);
`default_nettype wire

// ===== tb/tb_serial_channel_status_control.sv
// Directed testbench for the serial status and run-control block
`timescale 1ns/10ps
`default_nettype none
`include "serial_status_defines.vh"
module tb_serial_channel_status_control;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [`ADDR_W-1:0] i_addr = 20'h00000;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [1:0] rxe = 2'h3, txe = 2'h3, slave = 2'h0, par_en = 2'h1, odd = 2'h0, eng_clk = 2'h0;
   logic [1:0] t_start = 2'h0, t_end = 2'h0, rx_done = 2'h0, stop_ok = 2'h3, rx_par = 2'h0;
   logic [1:0] rx_store = 2'h0, tx_taken = 2'h0, buf_wr = 2'h0, buf_rd = 2'h0;
   logic [15:0] rx_data = 16'h0000;
   logic [7:0] o_rdata;
   logic [1:0] pin;
   logic [1:0] enabled;
   int n_fail = 0;
   int samples_checked = 0;

   serial_channel_status_control dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_receive_enable_bit(rxe), .i_transmit_enable(txe),
      .i_slave_transmit_mode(slave), .i_parity_enable(par_en), .i_parity_odd(odd),
      .i_transfer_start(t_start), .i_transfer_end(t_end), .i_rx_done(rx_done), .i_rx_stop_ok(stop_ok),
      .i_rx_data(rx_data), .i_rx_parity_bit(rx_par), .i_rx_store(rx_store), .i_tx_taken(tx_taken),
      .i_engine_clock(eng_clk), .i_buffer_write(buf_wr), .i_buffer_read(buf_rd),
      .o_serial_clock_pin(pin), .o_channel_enabled(enabled), .o_channel_abort(), .o_channel_halt()
   );

   initial forever #10 i_clk = ~i_clk;

   task automatic tick;
      @(negedge i_clk);
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      @(negedge i_clk);
      i_addr = a;
      i_wdata = d;
      i_wr = 1'b1;
      @(negedge i_clk);
      i_wr = 1'b0;
   endtask

   // Read data stands one cycle only, so sample it at the next falling edge
   task automatic rd(input logic [19:0] a, input logic [7:0] m, input logic [7:0] e);
      @(negedge i_clk);
      i_addr = a;
      i_rd = 1'b1;
      @(negedge i_clk);
      i_rd = 1'b0;
      chk(o_rdata & m, e);
   endtask

   task automatic print_verdict;
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Whole sequence needs about a hundred cycles
   initial begin
      repeat (5000) @(posedge i_clk);
      n_fail++;
      print_verdict;
   end

   initial begin
      repeat (3) @(negedge i_clk);
      i_rst = 1'b0;
      rd(`ADDR_ENABLE, 8'hFF, 8'h00);
      rd(`ADDR_STATUS1, 8'hFF, 8'h00);
      chk({6'h00, pin}, 8'h03);
      $display("test reset done");
      repeat (4) tick;
      wr(`ADDR_START, 8'h03);
      rd(`ADDR_START, 8'hFF, 8'h00);
      rd(`ADDR_ENABLE, 8'hFF, 8'h03);
      wr(`ADDR_STOP, 8'h01);
      rd(`ADDR_ENABLE, 8'hFF, 8'h02);
      rd(`ADDR_STOP, 8'hFF, 8'h00);
      $display("test triggers done");
      wr(`ADDR_CLK_LEVEL, 8'h00);
      eng_clk = 2'h2;
      tick;
      tick;
      chk({6'h00, pin}, 8'h02);
      eng_clk = 2'h0;
      wr(`ADDR_CLK_LEVEL, 8'h03);
      tick;
      chk({6'h00, pin}, 8'h01);
      $display("test clock pin done");
      stop_ok = 2'h0;
      rx_done = 2'h3;
      tick;
      rx_done = 2'h0;
      stop_ok = 2'h3;
      rd(`ADDR_STATUS1, 8'h04, 8'h04);
      rd(`ADDR_STATUS0, 8'h04, 8'h00);
      wr(`ADDR_FLAG_CLR1, 8'h04);
      rd(`ADDR_STATUS1, 8'h04, 8'h00);
      rx_data = 16'h0001;
      rx_done = 2'h1;
      tick;
      rx_done = 2'h0;
      rd(`ADDR_STATUS0, 8'h22, 8'h22);
      wr(`ADDR_FLAG_CLR0, 8'h02);
      rd(`ADDR_STATUS0, 8'h02, 8'h00);
      rx_par = 2'h1;
      rx_done = 2'h1;
      tick;
      rx_done = 2'h0;
      rd(`ADDR_STATUS0, 8'h02, 8'h00);
      odd = 2'h1;
      rx_done = 2'h1;
      tick;
      rx_done = 2'h0;
      odd = 2'h0;
      rx_par = 2'h0;
      rd(`ADDR_STATUS0, 8'h02, 8'h02);
      wr(`ADDR_FLAG_CLR0, 8'h02);
      $display("test receive errors done");
      buf_wr = 2'h1;
      tick;
      buf_wr = 2'h0;
      rd(`ADDR_STATUS0, 8'h21, 8'h21);
      wr(`ADDR_FLAG_CLR0, 8'h01);
      rd(`ADDR_STATUS0, 8'h01, 8'h00);
      rx_store = 2'h1;
      tick;
      rx_store = 2'h0;
      rd(`ADDR_STATUS0, 8'h01, 8'h01);
      wr(`ADDR_FLAG_CLR0, 8'h01);
      buf_rd = 2'h1;
      tick;
      buf_rd = 2'h0;
      rd(`ADDR_STATUS0, 8'h21, 8'h00);
      rx_store = 2'h1;
      tick;
      rx_store = 2'h0;
      rd(`ADDR_STATUS0, 8'h21, 8'h20);
      $display("test overrun done");
      wr(`ADDR_START, 8'h01);
      slave = 2'h1;
      tick;
      t_start = 2'h1;
      tick;
      t_start = 2'h0;
      rd(`ADDR_STATUS0, 8'h61, 8'h41);
      wr(`ADDR_START, 8'h01);
      rd(`ADDR_STATUS0, 8'h41, 8'h01);
      rd(`ADDR_ENABLE, 8'hFF, 8'h03);
      t_start = 2'h1;
      tick;
      t_start = 2'h0;
      rd(`ADDR_STATUS0, 8'h40, 8'h40);
      t_end = 2'h1;
      tick;
      t_end = 2'h0;
      rd(`ADDR_STATUS0, 8'h40, 8'h00);
      wr(`ADDR_STOP, 8'h03);
      rd(`ADDR_ENABLE, 8'hFF, 8'h00);
      rd(`ADDR_STATUS0, 8'h01, 8'h01);
      chk({6'h00, enabled}, 8'h00);
      $display("test transfer control done");
      wr(`ADDR_START, 8'h03);
      i_rst = 1'b1;
      repeat (3) tick;
      i_rst = 1'b0;
      rd(`ADDR_ENABLE, 8'hFF, 8'h00);
      rd(`ADDR_STATUS0, 8'hFF, 8'h00);
      chk({6'h00, pin}, 8'h03);
      $display("test mid-run reset done");
      print_verdict;
   end
endmodule // tb_serial_channel_status_control
`default_nettype wire
